/* hw/ssc_pkg.sv */
// Functional notes
// R1 - Eight bit word, bit zero sent first
// R2 - Sample data on serial clock rising edge
// R3 - Strobe rise copies shift register to settings
// R4 - Strobe high blocks serial clock shifting
// R5 - Latched settings act at strobe edge
// R6 - Direction and mode wait for step edge
// R7 - First step clock drives pair a
// R8 - Shared clock in clock mode drives pair b
// R9 - Each step edge advances one step
// R10 - Mode picks full step or half step
// R11 - Direction picks forward or reverse order
// R12 - Counter reset forces initial position
// R13 - Output enable drives or floats outputs
// R14 - Four bit divisor picks sixteen levels
// R15 - Source bit picks internal or external
// R16 - Hold freezes internal clock, no advance
// R17 - Reset at strobe, resume next step edge
// R18 - Disabled outputs float, counter keeps advancing
// R19 - Forward lags channel two, reverse leads
// R20 - Settings hold until next strobe rise
package ssc_pkg;
    localparam int WORD_BITS = 8;
    // Field positions in the latched word
    localparam int F_MODE = 0;
    localparam int F_DIR = 1;
    localparam int F_HOLD = 2;
    localparam int F_CRST = 3;
    localparam int F_OE = 4;
    // Divisor kept clear of the select bit so all sixteen levels reach it
    localparam int F_DIV_LO = 1;
    localparam int F_DIV_HI = 4;
    localparam int F_SRC = 0;
    localparam int F_PAIR = 5;
    localparam int F_B_PWM = 6;
    // Word select in bits 7 of the word
    localparam int F_SEL = 7;
    localparam logic [7:0] RST_WORD = 8'h00;
    localparam logic [2:0] POS_INIT = 3'h0;
    localparam logic [3:0] DIV_INIT = 4'h0;
    localparam int SYNC_STAGES = 2;
endpackage

/* hw/ssc_stepper.sv */
`timescale 1ns/10ps
`default_nettype none
module ssc_stepper
(
    input  wire logic       ref_clk,
    input  wire logic       reset,
    input  wire logic       step_edge,
    input  wire logic       strobe_edge,
    input  wire logic       cfg_mode,
    input  wire logic       cfg_dir,
    input  wire logic       cfg_hold,
    input  wire logic       cfg_crst,
    input  wire logic       cfg_oe,
    output logic      [1:0] phase_ch1,
    output logic      [1:0] phase_ch2,
    output logic            drive_en,
    output logic      [2:0] position
);
    logic [2:0] pos_r;
    logic [2:0] pos_nxt;
    logic       oe_r;
    logic [1:0] ch1_r;
    logic [1:0] ch2_r;
    logic [2:0] stride;
    logic       adv;

    // Mode and direction are read only on a step edge, so a new word
    // takes hold with the first step after its strobe
    // Full step keeps parity: from an even start both channels stay on
    assign stride = cfg_mode ? 3'h1 : 3'h2;                 // [R6] [R10]
    assign adv = step_edge && !cfg_hold && !cfg_crst;       // [R9] [R16]
    assign pos_nxt = cfg_dir ? 3'(pos_r - stride)
                             : 3'(pos_r + stride);          // [R6] [R11]

    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            pos_r <= ssc_pkg::POS_INIT;
            oe_r  <= 1'b0;
        end
        else
        begin
            if (strobe_edge)
                oe_r <= cfg_oe;                             // [R13] [R18]
            if (cfg_crst)
                pos_r <= ssc_pkg::POS_INIT;                 // [R12] [R17]
            else if (adv)
                pos_r <= pos_nxt;                           // [R9]
        end
    end

    // Channel 2 is a quarter period behind channel 1 going forward
    function automatic logic [1:0] ch_drive(input logic [2:0] p);
        case (p)
            3'h0:    ch_drive = 2'b10;
            3'h1:    ch_drive = 2'b10;
            3'h2:    ch_drive = 2'b10;
            3'h3:    ch_drive = 2'b00;
            3'h4:    ch_drive = 2'b01;
            3'h5:    ch_drive = 2'b01;
            3'h6:    ch_drive = 2'b01;
            default: ch_drive = 2'b00;
        endcase
    endfunction

    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            ch1_r <= 2'b00;
            ch2_r <= 2'b00;
        end
        else
        begin
            ch1_r <= ch_drive(pos_r);                       // [R19]
            ch2_r <= ch_drive(3'(pos_r - 3'h2));            // [R19]
        end
    end

    assign phase_ch1 = ch1_r;
    assign phase_ch2 = ch2_r;
    assign drive_en  = oe_r;
    assign position  = pos_r;

    a_hold_freezes: assert property (                       // [R16]
        @(posedge ref_clk) disable iff (reset)
        cfg_hold && !cfg_crst |=> pos_r == $past(pos_r))
        else $error("position moved during hold");
    a_crst_init: assert property (                          // [R12]
        @(posedge ref_clk) disable iff (reset)
        cfg_crst |=> pos_r == ssc_pkg::POS_INIT)
        else $error("counter reset did not hold initial");
endmodule
`default_nettype wire

/* hw/ssc_top.sv */
`timescale 1ns/10ps
`default_nettype none
module ssc_top
(
    input  wire logic       ref_clk,
    input  wire logic       reset,
    input  wire logic       serial_clk,
    input  wire logic       serial_data,
    input  wire logic       latch_strobe,
    input  wire logic       step_clock_pair_a,
    input  wire logic       step_clock_or_pwm_pair_b,
    output logic      [1:0] a_phase_ch1,
    output logic      [1:0] a_phase_ch2,
    output logic            a_drive_en,
    output logic      [2:0] a_position,
    output logic      [1:0] b_phase_ch3,
    output logic      [1:0] b_phase_ch4,
    output logic            b_drive_en,
    output logic      [2:0] b_position,
    output logic            b_pwm_mode,
    output logic      [3:0] ref_divisor,
    output logic            ref_external,
    output logic      [7:0] shift_word
);
    // Two-stage synchronisers for all pin inputs
    logic [1:0] s_sclk;
    logic [1:0] s_data;
    logic [1:0] s_stb;
    logic [1:0] s_ca;
    logic [1:0] s_cb;
    logic       sclk_d;
    logic       stb_d;
    logic       ca_d;
    logic       cb_d;
    logic [7:0] shift_r;
    logic [7:0] cfg_a_r;
    logic [7:0] cfg_b_r;
    logic [7:0] ref_r;
    logic       hold_a_r;
    logic       hold_b_r;
    logic       ica_r;
    logic       icb_r;
    wire  [1:0] tgt;
    wire        sclk_rise;
    wire        stb_rise;
    wire        wr_ref;
    wire        wr_a;
    wire        wr_b;
    wire        ca_int;
    wire        cb_int;
    wire        step_a;
    wire        step_b;

    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            s_sclk <= 2'b00;
            s_data <= 2'b00;
            s_stb  <= 2'b00;
            s_ca   <= 2'b00;
            s_cb   <= 2'b00;
        end
        else
        begin
            s_sclk <= {s_sclk[0], serial_clk};
            s_data <= {s_data[0], serial_data};
            s_stb  <= {s_stb[0], latch_strobe};
            s_ca   <= {s_ca[0], step_clock_pair_a};
            s_cb   <= {s_cb[0], step_clock_or_pwm_pair_b};
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            sclk_d <= 1'b0;
            stb_d  <= 1'b0;
            ca_d   <= 1'b0;
            cb_d   <= 1'b0;
        end
        else
        begin
            sclk_d <= s_sclk[1];
            stb_d  <= s_stb[1];
            ca_d   <= s_ca[1];
            cb_d   <= s_cb[1];
        end
    end

    assign sclk_rise = s_sclk[1] && !sclk_d && !s_stb[1];   // [R2] [R4]
    assign stb_rise  = s_stb[1] && !stb_d;                  // [R3]

    // Shift toward bit 0 so the first bit lands in bit 0
    always_ff @(posedge ref_clk)
    begin
        if (reset)
            shift_r <= ssc_pkg::RST_WORD;
        else if (sclk_rise)
            shift_r <= {s_data[1], shift_r[7:1]};           // [R1] [R2]
    end

    // Word routing: bit 7 picks reference word, else bit 5 picks pair
    function automatic logic [1:0] route(input logic [7:0] w);
        if (w[ssc_pkg::F_SEL])
            route = 2'h2;
        else if (w[ssc_pkg::F_PAIR])
            route = 2'h1;
        else
            route = 2'h0;
    endfunction

    assign tgt    = route(shift_r);
    assign wr_ref = stb_rise && (tgt == 2'h2);
    assign wr_a   = stb_rise && (tgt == 2'h0);
    assign wr_b   = stb_rise && (tgt == 2'h1);

    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            cfg_a_r <= ssc_pkg::RST_WORD;
            cfg_b_r <= ssc_pkg::RST_WORD;
            ref_r   <= ssc_pkg::RST_WORD;
        end
        else
        begin
            if (wr_a)
                cfg_a_r <= shift_r;                         // [R3] [R20]
            if (wr_b)
                cfg_b_r <= shift_r;                         // [R3] [R20]
            if (wr_ref)
                ref_r <= shift_r;                           // [R5]
        end
    end

    // Internal clock freezes at the level seen when hold is entered
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            hold_a_r <= 1'b0;
            hold_b_r <= 1'b0;
            ica_r    <= 1'b0;
            icb_r    <= 1'b0;
        end
        else
        begin
            hold_a_r <= cfg_a_r[ssc_pkg::F_HOLD];
            hold_b_r <= cfg_b_r[ssc_pkg::F_HOLD];
            ica_r    <= ca_int;
            icb_r    <= cb_int;
        end
    end

    assign ca_int = cfg_a_r[ssc_pkg::F_HOLD] ? ica_r : s_ca[1];   // [R16]
    assign cb_int = cfg_b_r[ssc_pkg::F_HOLD] ? icb_r : s_cb[1];   // [R16]
    assign step_a = ca_int && !ca_d && !hold_a_r
                    && !cfg_a_r[ssc_pkg::F_HOLD];           // [R7]
    assign step_b = cb_int && !cb_d && !hold_b_r
                    && !cfg_b_r[ssc_pkg::F_HOLD]
                    && !cfg_b_r[ssc_pkg::F_B_PWM];          // [R8]

    ssc_stepper u_pair_a
    (
        .ref_clk     (ref_clk),
        .reset       (reset),
        .step_edge   (step_a),
        .strobe_edge (wr_a),
        .cfg_mode    (cfg_a_r[ssc_pkg::F_MODE]),
        .cfg_dir     (cfg_a_r[ssc_pkg::F_DIR]),
        .cfg_hold    (cfg_a_r[ssc_pkg::F_HOLD]),
        .cfg_crst    (cfg_a_r[ssc_pkg::F_CRST]),
        .cfg_oe      (shift_r[ssc_pkg::F_OE]),
        .phase_ch1   (a_phase_ch1),
        .phase_ch2   (a_phase_ch2),
        .drive_en    (a_drive_en),
        .position    (a_position)
    );

    ssc_stepper u_pair_b
    (
        .ref_clk     (ref_clk),
        .reset       (reset),
        .step_edge   (step_b),
        .strobe_edge (wr_b),
        .cfg_mode    (cfg_b_r[ssc_pkg::F_MODE]),
        .cfg_dir     (cfg_b_r[ssc_pkg::F_DIR]),
        .cfg_hold    (cfg_b_r[ssc_pkg::F_HOLD]),
        .cfg_crst    (cfg_b_r[ssc_pkg::F_CRST]),
        .cfg_oe      (shift_r[ssc_pkg::F_OE]),
        .phase_ch1   (b_phase_ch3),
        .phase_ch2   (b_phase_ch4),
        .drive_en    (b_drive_en),
        .position    (b_position)
    );

    assign b_pwm_mode   = cfg_b_r[ssc_pkg::F_B_PWM];
    assign ref_divisor  = ref_r[ssc_pkg::F_DIV_HI:ssc_pkg::F_DIV_LO]; // [R14]
    assign ref_external = ref_r[ssc_pkg::F_SRC];            // [R15]
    assign shift_word   = shift_r;

    a_no_shift_strobe: assert property (                    // [R4]
        @(posedge ref_clk) disable iff (reset)
        s_stb[1] && stb_d |=> shift_r == $past(shift_r))
        else $error("shift moved while strobe high");
    a_latch_copy: assert property (                         // [R3]
        @(posedge ref_clk) disable iff (reset)
        wr_a |=> cfg_a_r == $past(shift_r))
        else $error("pair a settings not latched");
    a_cfg_stable: assert property (                         // [R20]
        @(posedge ref_clk) disable iff (reset)
        !wr_b |=> cfg_b_r == $past(cfg_b_r))
        else $error("pair b settings changed without strobe");
    a_ref_source: assert property (                         // [R15]
        @(posedge ref_clk) disable iff (reset)
        wr_ref |=> ref_external == $past(shift_r[0]))
        else $error("reference source not latched");
    a_pwm_no_step: assert property (                        // [R8]
        @(posedge ref_clk) disable iff (reset)
        b_pwm_mode && !wr_b && !cfg_b_r[3] |=> $stable(b_position))
        else $error("pair b stepped in pwm mode");
    a_shift_in: assert property (                           // [R2]
        @(posedge ref_clk) disable iff (reset)
        sclk_rise |=> shift_r[7] == $past(s_data[1]))
        else $error("serial bit not sampled");

    a_latch_b: assert property (                            // [R3]
        @(posedge ref_clk) disable iff (reset)
        wr_b |=> cfg_b_r == $past(shift_r))
        else $error("pair b settings not latched");
    a_cfg_a_stable: assert property (                       // [R20]
        @(posedge ref_clk) disable iff (reset)
        !wr_a |=> cfg_a_r == $past(cfg_a_r))
        else $error("pair a settings changed without strobe");
    a_ref_stable: assert property (                         // [R20]
        @(posedge ref_clk) disable iff (reset)
        !wr_ref |=> ref_r == $past(ref_r))
        else $error("reference word changed without strobe");
    a_ref_divisor: assert property (                        // [R14]
        @(posedge ref_clk) disable iff (reset)
        wr_ref |=> ref_divisor
            == $past(shift_r[ssc_pkg::F_DIV_HI:ssc_pkg::F_DIV_LO]))
        else $error("reference divisor not latched");
    a_shift_idle: assert property (                         // [R2]
        @(posedge ref_clk) disable iff (reset)
        !sclk_rise |=> shift_r == $past(shift_r))
        else $error("shift moved without serial clock");

    // Pin edge seen in the first sync stage, internal edge one cycle on
    sequence s_stb_enter;
        !s_stb[0] ##1 s_stb[0];
    endsequence
    sequence s_sclk_enter;
        !s_sclk[0] ##1 s_sclk[0];
    endsequence
    sequence s_ca_enter;
        !s_ca[0] ##1 s_ca[0];
    endsequence
    sequence s_cb_enter;
        !s_cb[0] ##1 s_cb[0];
    endsequence

    a_stb_to_latch: assert property (                       // [R3]
        @(posedge ref_clk) disable iff (reset)
        s_stb_enter |-> ##1 stb_rise)
        else $error("strobe rise not detected");
    a_sclk_to_shift: assert property (                      // [R2]
        @(posedge ref_clk) disable iff (reset)
        s_sclk_enter ##1 !s_stb[1] |-> sclk_rise)
        else $error("serial clock rise not detected");
    a_sclk_blocked: assert property (                       // [R4]
        @(posedge ref_clk) disable iff (reset)
        s_sclk_enter ##1 s_stb[1] |-> !sclk_rise)
        else $error("serial clock taken while strobe high");
    a_ca_to_step: assert property (                         // [R7]
        @(posedge ref_clk) disable iff (reset)
        s_ca_enter ##1 (!cfg_a_r[ssc_pkg::F_HOLD] && !hold_a_r) |-> step_a)
        else $error("pair a step edge missed");
    a_cb_to_step: assert property (                         // [R8]
        @(posedge ref_clk) disable iff (reset)
        s_cb_enter ##1 (!cfg_b_r[ssc_pkg::F_HOLD] && !hold_b_r
                        && !b_pwm_mode) |-> step_b)
        else $error("pair b step edge missed");

    a_a_moves: assert property (                            // [R9]
        @(posedge ref_clk) disable iff (reset)
        step_a && !cfg_a_r[ssc_pkg::F_CRST] |=> !$stable(a_position))
        else $error("pair a did not advance");
    a_b_moves: assert property (                            // [R9]
        @(posedge ref_clk) disable iff (reset)
        step_b && !cfg_b_r[ssc_pkg::F_CRST] |=> !$stable(b_position))
        else $error("pair b did not advance");
    a_a_still: assert property (                            // [R9]
        @(posedge ref_clk) disable iff (reset)
        !step_a && !cfg_a_r[ssc_pkg::F_CRST] |=> $stable(a_position))
        else $error("pair a moved without step");
    a_b_still: assert property (                            // [R9]
        @(posedge ref_clk) disable iff (reset)
        !step_b && !cfg_b_r[ssc_pkg::F_CRST] |=> $stable(b_position))
        else $error("pair b moved without step");

    a_a_oe_latch: assert property (                         // [R13]
        @(posedge ref_clk) disable iff (reset)
        wr_a |=> a_drive_en == $past(shift_r[ssc_pkg::F_OE]))
        else $error("pair a enable not latched");
    a_b_oe_latch: assert property (                         // [R13]
        @(posedge ref_clk) disable iff (reset)
        wr_b |=> b_drive_en == $past(shift_r[ssc_pkg::F_OE]))
        else $error("pair b enable not latched");
    a_a_oe_hold: assert property (                          // [R20]
        @(posedge ref_clk) disable iff (reset)
        !wr_a |=> $stable(a_drive_en))
        else $error("pair a enable changed without strobe");
    a_b_oe_hold: assert property (                          // [R20]
        @(posedge ref_clk) disable iff (reset)
        !wr_b |=> $stable(b_drive_en))
        else $error("pair b enable changed without strobe");

    a_a_clk_freeze: assert property (                       // [R16]
        @(posedge ref_clk) disable iff (reset)
        cfg_a_r[ssc_pkg::F_HOLD] |=> ica_r == $past(ica_r))
        else $error("pair a internal clock moved in hold");
    a_b_clk_freeze: assert property (                       // [R16]
        @(posedge ref_clk) disable iff (reset)
        cfg_b_r[ssc_pkg::F_HOLD] |=> icb_r == $past(icb_r))
        else $error("pair b internal clock moved in hold");
endmodule
`default_nettype wire

/* dv/ssc_host.sv */
`timescale 1ns/10ps
`default_nettype none
module ssc_host
(
    input  wire logic ref_clk,
    output logic      serial_clk,
    output logic      serial_data,
    output logic      latch_strobe
);
    initial
    begin
        serial_clk = 1'b0;
        serial_data = 1'b0;
        latch_strobe = 1'b0;
    end

    // Bad frame toggles the clock while latched, to prove it is ignored
    task automatic send(input logic [7:0] w, input logic bad);
        for (int i = 0; i < 8; i++)
        begin
            serial_data <= w[i];
            repeat (4) @(posedge ref_clk);
            serial_clk <= 1'b1;
            repeat (8) @(posedge ref_clk);
            serial_clk <= 1'b0;
            repeat (4) @(posedge ref_clk);
        end
        latch_strobe <= 1'b1;
        for (int i = 0; i < 8; i++)
        begin
            repeat (4) @(posedge ref_clk);
            serial_clk <= bad & ~serial_clk;
            serial_data <= ~serial_data;
        end
        repeat (4) @(posedge ref_clk);
        latch_strobe <= 1'b0;
        repeat (4) @(posedge ref_clk);
    endtask
endmodule
`default_nettype wire

/* dv/stepper_serial_control_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module stepper_serial_control_tb;
    logic        ref_clk = 1'b0;
    logic        reset = 1'b1;
    logic        sclk;
    logic        sdat;
    logic        stb;
    logic [1:0]  step_clk = 2'h0;
    logic [1:0]  ph1, ph2, ph3, ph4;
    logic        en_a, en_b, pwm_b, ext;
    logic [2:0]  pos_a, pos_b;
    logic [3:0]  div;
    logic [7:0]  sw;
    logic [7:0]  w;
    logic [31:0] r;
    logic [15:0] tab [12] = '{16'h3010, 16'h2014, 16'h1010, 16'h3000,
        16'h1010, 16'h3013, 16'h2018, 16'h1011, 16'h0330, 16'h0232,
        16'h0270, 16'h0331};
    int          err_count = 0;
    int          total_checks = 0;
    int          cycles = 0;
    int          seed = 32'h77a0325e;
    int          m_pos[2], m_mode[2], m_dir[2], m_hold[2], m_crst[2];
    int          m_oe[2];
    int          m_pwm = 0, m_div = 0, m_ext = 0, m_sw = 0;

    always #5 ref_clk = ~ref_clk;

    ssc_top u_dut
    (
        .ref_clk                  (ref_clk),
        .reset                    (reset),
        .serial_clk               (sclk),
        .serial_data              (sdat),
        .latch_strobe             (stb),
        .step_clock_pair_a        (step_clk[0]),
        .step_clock_or_pwm_pair_b (step_clk[1]),
        .a_phase_ch1              (ph1),
        .a_phase_ch2              (ph2),
        .a_drive_en               (en_a),
        .a_position               (pos_a),
        .b_phase_ch3              (ph3),
        .b_phase_ch4              (ph4),
        .b_drive_en               (en_b),
        .b_position               (pos_b),
        .b_pwm_mode               (pwm_b),
        .ref_divisor              (div),
        .ref_external             (ext),
        .shift_word               (sw)
    );

    ssc_host u_host
    (
        .ref_clk      (ref_clk),
        .serial_clk   (sclk),
        .serial_data  (sdat),
        .latch_strobe (stb)
    );

    task automatic summarize();
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // Hang guard, well above the expected run length
    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 60000)
        begin
            err_count++;
            summarize();
        end
    end

    task automatic chk(input string nm, input logic [7:0] e,
                       input logic [7:0] g);
        total_checks++;
        if (g !== e)
        begin
            err_count++;
            $display("[FAIL] %s exp %h got %h", nm, e, g);
        end
    endtask

    // Eight-step table, {positive, negative} drive per channel
    function automatic logic [1:0] drv(input int p);
        if (p % 8 < 3)
            return 2'b10;
        else if (p % 8 == 3 || p % 8 == 7)
            return 2'b00;
        else
            return 2'b01;
    endfunction

    task automatic check_all();
        chk("a_phase_ch1", {6'h0, drv(m_pos[0])}, {6'h0, ph1});
        chk("a_phase_ch2", {6'h0, drv(m_pos[0] + 6)}, {6'h0, ph2});
        chk("b_phase_ch3", {6'h0, drv(m_pos[1])}, {6'h0, ph3});
        chk("b_phase_ch4", {6'h0, drv(m_pos[1] + 6)}, {6'h0, ph4});
        chk("a_position", 8'(m_pos[0]), {5'h0, pos_a});
        chk("b_position", 8'(m_pos[1]), {5'h0, pos_b});
        chk("a_drive_en", 8'(m_oe[0]), {7'h0, en_a});
        chk("b_drive_en", 8'(m_oe[1]), {7'h0, en_b});
        chk("b_pwm_mode", 8'(m_pwm), {7'h0, pwm_b});
        chk("ref_divisor", 8'(m_div), {4'h0, div});
        chk("ref_external", 8'(m_ext), {7'h0, ext});
        chk("shift_word", 8'(m_sw), sw);
    endtask

    task automatic apply(input logic [7:0] x);
        int p;
        p = int'(x[5]);
        m_sw = x;
        if (x[7])
        begin
            m_div = x[ssc_pkg::F_DIV_HI:ssc_pkg::F_DIV_LO];
            m_ext = x[0];
        end
        else
        begin
            m_mode[p] = x[0];
            m_dir[p] = x[1];
            m_hold[p] = x[2];
            m_crst[p] = x[3];
            m_oe[p] = x[4];
            if (p == 1)
                m_pwm = x[6];
            if (x[3])
                m_pos[p] = 0;
        end
    endtask

    task automatic step(input int p);
        step_clk[p] <= 1'b1;
        repeat (8) @(posedge ref_clk);
        step_clk[p] <= 1'b0;
        repeat (8) @(posedge ref_clk);
        // Disabled outputs still count, only hold, reset and pwm block
        if (!(m_hold[p] || m_crst[p] || (p == 1 && m_pwm)))
            m_pos[p] = (m_pos[p] + 8 + (2 - m_mode[p])
                        * (m_dir[p] ? -1 : 1)) % 8;
        check_all();
    endtask

    task automatic run(input logic [7:0] x, input logic bad,
                       input int na, input int nb);
        u_host.send(x, bad);
        apply(x);
        check_all();
        repeat (na) step(0);
        repeat (nb) step(1);
    endtask

    initial
    begin
        repeat (16) @(posedge ref_clk);
        reset <= 1'b0;
        repeat (4) @(posedge ref_clk);
        check_all();
        for (int d = 0; d < 16; d++)
        begin
            w = {1'b1, 2'(d), 4'(d), d[3]};
            run(w, d[0], 0, 0);
        end
        foreach (tab[i])
            run(tab[i][7:0], 1'b0, tab[i][15:12], tab[i][11:8]);
        // Random words stay in half step so odd positions stay legal
        for (int i = 0; i < 24; i++)
        begin
            r = $random(seed);
            w = r[7:0];
            if (!w[7])
                w[0] = 1'b1;
            if (!w[7] && !w[5])
                w[6] = 1'b0;
            run(w, r[8], r[10:9], r[12:11]);
        end
        summarize();
    end
endmodule
`default_nettype wire
